// ### inc/emc_pkg.sv
// Shared constants and types for the emulation mode control block
package emc_pkg;
	// Core timing: one machine cycle is six states of two clocks each
	localparam int unsigned CLK_HZ          = 50000000;
	localparam int unsigned STATES_PER_MC   = 6;
	localparam int unsigned CLKS_PER_STATE  = 2;
	localparam logic [2:0]  STATE_S1        = 3'h0;
	localparam logic [2:0]  STATE_S2        = 3'h1;
	localparam logic [2:0]  STATE_S4        = 3'h3;
	localparam logic [2:0]  STATE_LAST      = 3'(STATES_PER_MC - 1);
	localparam logic        PHASE_LAST      = 1'(CLKS_PER_STATE - 1);
	// States spent fetching the ignored NOP byte after exit
	localparam logic [2:0]  EXIT_STATES     = 3'h4;
	// Opcode forced into the instruction register on exit
	localparam logic [7:0]  OPC_NOP         = 8'h00;
	// Select levels
	localparam logic        SEL_PROGRAM     = 1'b0;
	localparam logic        SEL_DATA        = 1'b1;
	localparam logic        TYPE_ADVANCED   = 1'b1;

	typedef enum logic [1:0] {
		EMC_RUN,
		EMC_ENTER,
		EMC_HALT,
		EMC_EXIT
	} emc_state_t;

	// Core timing indications
	typedef struct packed {
		logic [2:0] state_idx;
		logic       phase;
		logic       state_end;
		logic       s1_end;
	} emc_timing_t;

	// Emulator access request decoded from pins
	typedef struct packed {
		logic       internal_space;
		logic       wr;
		logic       rd;
	} emc_access_t;

	// Pin drive for the normal read/write control pins and ports
	typedef struct packed {
		logic       ctl_pullup_only;
		logic       low_port_float;
		logic       high_port_hiz;
	} emc_pindrv_t;

	function automatic logic emc_is_state_end(input logic ph);
		return ph == PHASE_LAST;
	endfunction : emc_is_state_end
endpackage : emc_pkg

// ### logic/emc_state_timer.sv
// Machine cycle state and phase counter of the core
module emc_state_timer
	import emc_pkg::*;
(
	// Clock and control
	input  wire logic        i_sys_clk,
	input  wire logic        i_srst,
	input  wire logic        i_ce,
	input  wire logic        i_freeze,
	// Timing out
	output emc_timing_t      o_timing
);
	logic [2:0] state_r;
	logic [2:0] state_nxt;
	logic       phase_r;
	wire        run     = i_ce & ~i_freeze;
	wire        st_end  = emc_is_state_end(phase_r);

	assign state_nxt = (state_r == STATE_LAST) ? STATE_S1 : 3'(state_r + 3'h1);
	assign o_timing.state_idx = state_r;
	assign o_timing.phase     = phase_r;
	assign o_timing.state_end = run & st_end;
	assign o_timing.s1_end    = run & st_end & (state_r == STATE_S1);

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			state_r <= STATE_S1;
			phase_r <= 1'b0;
		end else if (run) begin
			phase_r <= st_end ? 1'b0 : 1'b1;
			if (st_end)
				state_r <= state_nxt;
		end
	end
endmodule : emc_state_timer

// ### logic/emc_access_decode.sv
// Decodes the address-space select and emulator strobes into access and pin drive
module emc_access_decode
	import emc_pkg::*;
(
	// Mode inputs
	input  wire logic        i_emu,
	input  wire logic        i_standard,
	input  wire logic        i_port_float_control,
	// Select pin level and drive enable, before the pull is applied
	input  wire logic        i_sel_in,
	input  wire logic        i_sel_in_oe,
	input  wire logic        i_write_n,
	input  wire logic        i_read_n,
	// Decoded
	output emc_access_t      o_access,
	output emc_pindrv_t      o_pindrv
);
	// Undriven select defaults low through the internal resistor
	wire sel_level = i_sel_in_oe & i_sel_in;

	assign o_access.internal_space = i_emu & ~sel_level;
	assign o_access.wr             = i_emu & ~sel_level & ~i_write_n;
	assign o_access.rd             = i_emu & ~sel_level & ~i_read_n;
	assign o_pindrv.ctl_pullup_only = i_emu & sel_level;
	assign o_pindrv.low_port_float  = i_emu & sel_level & i_standard;
	assign o_pindrv.high_port_hiz   = i_emu & sel_level & i_standard
		& i_port_float_control;
endmodule : emc_access_decode

// ### logic/emc_top.sv
// Emulation mode entry, exit and address-space select control
// Overview of operation
// - Normal mode: select low program, high data
// - Select low: internal space, emulator strobes
// - Select high: external memory, control pins pulled
// - Standard type: low port floats, high port per control bit
// - Undriven select reads as low
// - Request high freezes clock; defaults low
// - Emulator reads and writes registers, RAM, memory
// - Request low releases clock, resumes mode
// - Active rises at end of next S1
// - Exit loads NOP into instruction register
// - Nine states later active falls at the second S4
// - Pulse once per machine cycle at S1
// - Type input high selects advanced at power-on
// - Type changes only at reset, never while running
module emc_top
	import emc_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        i_sys_clk,
	input  wire logic        i_srst,
	input  wire logic        i_ce,
	// Straps and emulator control
	input  wire logic        i_type_select_n,
	input  wire logic        i_emulation_request,
	input  wire logic        i_emulation_write_n,
	input  wire logic        i_emulation_read_n,
	input  wire logic        i_port_float_control,
	// Address-space select, two-way pin
	input  wire logic        i_address_space_select,
	input  wire logic        i_address_space_select_oe,
	output logic             o_address_space_select,
	output logic             o_address_space_select_oe,
	// Core access indication in normal mode
	input  wire logic        i_core_data_access,
	input  wire logic        i_core_mem_access,
	// Core side
	input  wire logic [7:0]  i_core_ir,
	output logic [7:0]       o_instruction_register,
	output logic             o_ir_load,
	output logic             o_core_freeze,
	output logic             o_standard_type,
	// Emulator-facing outputs
	output logic             o_emulation_active,
	output logic             o_s1_phase_clock,
	// Emulator access and pin drive
	output emc_access_t      o_access,
	output emc_pindrv_t      o_pindrv
);
	emc_state_t   state_r;
	emc_state_t   state_nxt;
	emc_timing_t  timing;
	emc_access_t  access_w;
	emc_pindrv_t  pindrv_w;
	logic         req_sync_r;
	logic         req_meta_r;
	logic         type_done_r;
	logic         standard_r;
	logic         active_r;
	logic         freeze_r;
	logic [2:0]   exit_cnt_r;
	logic [7:0]   ir_r;
	logic         ir_load_r;
	logic         sel_out_r;
	logic         sel_oe_r;
	logic         s1_r;

	// Core timing stops while frozen; oscillator keeps running
	emc_state_timer u_timer (
		.i_sys_clk (i_sys_clk),
		.i_srst    (i_srst),
		.i_ce      (i_ce),
		.i_freeze  (freeze_r),
		.o_timing  (timing)
	);

	emc_access_decode u_decode (
		.i_emu                (active_r),
		.i_standard           (standard_r),
		.i_port_float_control (i_port_float_control),
		.i_sel_in             (i_address_space_select),
		.i_sel_in_oe          (i_address_space_select_oe),
		.i_write_n            (i_emulation_write_n),
		.i_read_n             (i_emulation_read_n),
		.o_access             (access_w),
		.o_pindrv             (pindrv_w)
	);

	// Request defaults low: the pull-down is modelled by the bench driving 0
	wire req_high   = req_sync_r;
	// Entry needs the request still high, else a late drop would freeze with no way out
	wire enter_now  = (state_r == EMC_ENTER) & req_high & timing.s1_end;
	wire exit_start = (state_r == EMC_HALT) & ~req_high;
	wire exit_done  = (state_r == EMC_EXIT) & timing.state_end
		& (timing.state_idx == STATE_S4) & (exit_cnt_r >= EXIT_STATES - 3'h1);
	wire exit_step  = (state_r == EMC_EXIT) & timing.state_end;
	wire sel_drive  = ~active_r;
	wire sel_value  = i_core_data_access ? SEL_DATA : SEL_PROGRAM;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			EMC_RUN: begin
				if (req_high)
					state_nxt = EMC_ENTER;
			end
			EMC_ENTER: begin
				if (!req_high)
					state_nxt = EMC_RUN;
				else if (enter_now)
					state_nxt = EMC_HALT;
			end
			EMC_HALT: begin
				if (exit_start)
					state_nxt = EMC_EXIT;
			end
			EMC_EXIT: begin
				if (exit_done)
					state_nxt = EMC_RUN;
			end
		endcase
	end

	// Two-stage synchroniser for the asynchronous request
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			req_meta_r <= 1'b0;
			req_sync_r <= 1'b0;
		end else if (i_ce) begin
			req_meta_r <= i_emulation_request;
			req_sync_r <= req_meta_r;
		end
	end

	// Type is latched once after reset release and held until the next reset
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			type_done_r <= 1'b0;
			standard_r  <= 1'b0;
		end else if (i_ce && !type_done_r) begin
			type_done_r <= 1'b1;
			standard_r  <= (i_type_select_n != TYPE_ADVANCED);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst)
			state_r <= EMC_RUN;
		else if (i_ce)
			state_r <= state_nxt;
	end

	// Active rises with the freeze and falls after the exit NOP completes
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			active_r <= 1'b0;
			freeze_r <= 1'b0;
		end else if (i_ce) begin
			if (enter_now) begin
				active_r <= 1'b1;
				freeze_r <= 1'b1;
			end else if (exit_start) begin
				freeze_r <= 1'b0;
			end else if (exit_done) begin
				active_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst)
			exit_cnt_r <= 3'h0;
		else if (i_ce) begin
			if (exit_start)
				exit_cnt_r <= 3'h0;
			else if (exit_step && exit_cnt_r < EXIT_STATES)
				exit_cnt_r <= 3'(exit_cnt_r + 3'h1);
		end
	end

	// Stale opcode is replaced so a modified PC cannot run leftover code
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			ir_r      <= OPC_NOP;
			ir_load_r <= 1'b0;
		end else if (i_ce) begin
			ir_load_r <= exit_start;
			ir_r      <= exit_start ? OPC_NOP : i_core_ir;
		end
	end

	// Select pin: driven only in normal mode, released to the emulator otherwise
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			sel_out_r <= SEL_PROGRAM;
			sel_oe_r  <= 1'b0;
		end else if (i_ce) begin
			sel_oe_r  <= sel_drive & i_core_mem_access;
			sel_out_r <= sel_value;
		end
	end

	// One pulse per machine cycle, frozen with the core
	always_ff @(posedge i_sys_clk) begin
		if (i_srst)
			s1_r <= 1'b0;
		else if (i_ce)
			s1_r <= timing.s1_end;
	end

	// Register the decoded access so outputs come from flops
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_access <= '0;
			o_pindrv <= '0;
		end else if (i_ce) begin
			o_access <= access_w;
			o_pindrv <= pindrv_w;
		end
	end

	assign o_instruction_register   = ir_r;
	assign o_ir_load                = ir_load_r;
	assign o_core_freeze            = freeze_r;
	assign o_standard_type          = standard_r;
	assign o_emulation_active       = active_r;
	assign o_s1_phase_clock         = s1_r;
	assign o_address_space_select    = sel_out_r;
	assign o_address_space_select_oe = sel_oe_r;
endmodule : emc_top

// ### tb/emc_properties.sv
// Checker for emulation entry, exit and select decode
module emc_checker
	import emc_pkg::*;
(
	// Clock and reset
	input wire logic  i_sys_clk,
	input wire logic  i_srst,
	input wire logic  i_ce,
	// Watched pins
	input wire logic  i_address_space_select,
	input wire logic  i_address_space_select_oe,
	input wire logic  i_core_data_access,
	input logic       o_address_space_select,
	input logic       o_address_space_select_oe,
	input logic [7:0] o_instruction_register,
	input logic       o_ir_load,
	input logic       o_core_freeze,
	input logic       o_standard_type,
	input logic       o_emulation_active,
	input logic       o_s1_phase_clock,
	input emc_access_t o_access,
	input emc_pindrv_t o_pindrv
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_srst || !i_ce);
	wire logic sel_hi = i_address_space_select && i_address_space_select_oe;
	// Active level one clock earlier, kept in clocked code
	logic      act_prev_r;
	always_ff @(posedge i_sys_clk) begin
		act_prev_r <= o_emulation_active;
	end
	wire logic act2   = o_emulation_active && act_prev_r;
	a_s1_one_pulse: assert property (o_s1_phase_clock |=> !o_s1_phase_clock [*8])
		else $error("s1 pulse repeats too soon");
	a_exit_nop: assert property (o_ir_load |-> o_instruction_register == OPC_NOP)
		else $error("exit did not load nop");
	a_exit_release: assert property (o_ir_load |-> !o_core_freeze && $past(o_core_freeze))
		else $error("exit without clock release");
	a_entry_frozen: assert property (!$past(i_srst) && $rose(o_emulation_active) |-> o_core_freeze)
		else $error("active rose without freeze");
	a_exit_hold: assert property (!$past(i_srst) && $fell(o_core_freeze) |-> o_emulation_active [*8])
		else $error("active fell before four states");
	a_exit_bound: assert property (!$past(i_srst) && $fell(o_core_freeze) |-> ##[8:40] !o_emulation_active)
		else $error("active never fell after exit");
	a_access_idle: assert property (!o_emulation_active && !$past(o_emulation_active) |-> o_access == '0)
		else $error("access decoded outside emulation");
	a_space_decode: assert property (act2 |-> o_access.internal_space == !$past(sel_hi))
		else $error("wrong address space");
	a_pullup_ext: assert property (act2 |-> o_pindrv.ctl_pullup_only == $past(sel_hi))
		else $error("control pins not pulled in external space");
	a_sel_normal: assert property (o_address_space_select_oe |-> o_address_space_select == $past(i_core_data_access))
		else $error("select level does not follow access");
	a_type_fixed: assert property ($past(i_srst) || $past(i_srst, 2) || $stable(o_standard_type))
		else $error("type changed after reset");
endmodule : emc_checker

bind emc_top emc_checker emc_checker_inst (.*);

// ### tb/emc_emulator.sv
// Emulator model driving request, strobes and select pin
module emc_emulator
	import emc_pkg::*;
(
	// Clock and status
	input  wire logic i_sys_clk,
	input  wire logic i_active,
	// Emulator drive
	output logic      o_req,
	output logic      o_write_n,
	output logic      o_read_n,
	output logic      o_sel,
	output logic      o_sel_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_req = 1'b0;
		{o_write_n, o_read_n} = 2'h3;
		{o_sel, o_sel_oe} = 2'h2;
	end
	task request(input logic v);
		@(negedge i_sys_clk);
		o_req = v;
	endtask : request
	// A released select shows the inverse level, so a missing pull is seen
	task space(input logic v, input logic oe);
		@(negedge i_sys_clk);
		o_sel_oe = oe;
		o_sel    = oe ? v : ~v;
	endtask : space
	task automatic strobe(input logic w, input logic r);
		int n = 0;
		while (i_active !== 1'b1 && n < 40) begin
			@(negedge i_sys_clk);
			n++;
		end
		@(negedge i_sys_clk);
		o_write_n = w;
		o_read_n  = r;
	endtask : strobe
endmodule : emc_emulator

// ### tb/emc_bench.sv
// Self-checking bench for the emulation mode control block
module emc_bench;
	import emc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_sys_clk = 0, i_srst = 1, i_ce = 1, i_type_select_n = 1;
	logic i_port_float_control = 1, i_core_data_access = 0, i_core_mem_access = 0;
	logic [7:0] i_core_ir = 8'h5A;
	wire logic i_emulation_request, i_emulation_write_n, i_emulation_read_n;
	wire logic i_address_space_select, i_address_space_select_oe;
	logic o_address_space_select, o_address_space_select_oe, o_ir_load, o_core_freeze;
	logic o_standard_type, o_emulation_active, o_s1_phase_clock;
	logic [7:0] o_instruction_register;
	emc_access_t o_access;
	emc_pindrv_t o_pindrv;
	int error_cnt = 0, checked = 0;
	always #10 i_sys_clk = ~i_sys_clk;
	emc_top emc_top_inst (.*);
	emc_emulator emc_emulator_inst (.i_sys_clk(i_sys_clk), .i_active(o_emulation_active),
		.o_req(i_emulation_request), .o_write_n(i_emulation_write_n),
		.o_read_n(i_emulation_read_n), .o_sel(i_address_space_select),
		.o_sel_oe(i_address_space_select_oe));
	task check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	task close_out();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	task t_reset(input logic strap);
		@(negedge i_sys_clk);
		i_type_select_n = strap;
		i_srst = 1'b1;
		repeat (6) @(negedge i_sys_clk);
		i_srst = 1'b0;
		repeat (2) @(negedge i_sys_clk);
		check(o_standard_type, !strap);
		i_type_select_n = ~strap;
		repeat (3) @(negedge i_sys_clk);
		check(o_standard_type, !strap);
	endtask : t_reset
	task t_normal();
		i_core_mem_access = 1'b1;
		for (int d = 0; d < 2; d++) begin
			i_core_data_access = d[0];
			repeat (2) @(negedge i_sys_clk);
			check(o_address_space_select_oe, 1'b1);
			check(o_address_space_select, d[0]);
		end
		i_core_mem_access = 1'b0;
	endtask : t_normal
	task automatic t_period();
		int n = 0;
		while (o_s1_phase_clock !== 1'b1 && n < 30) begin
			@(negedge i_sys_clk);
			n++;
		end
		n = 0;
		do begin
			@(negedge i_sys_clk);
			n++;
		end while (o_s1_phase_clock !== 1'b1 && n < 30);
		check(n, 8'h0C);
	endtask : t_period
	task automatic t_emu(input logic sel, input logic oe, input logic std);
		logic lvl = sel & oe;
		int n = 0;
		int p = 0;
		emc_emulator_inst.request(1'b1);
		while (o_emulation_active !== 1'b1 && n < 40) begin
			@(negedge i_sys_clk);
			n++;
		end
		check(o_emulation_active, 1'b1);
		check(o_core_freeze, 1'b1);
		repeat (24) begin
			@(negedge i_sys_clk);
			p += o_s1_phase_clock;
		end
		check(p, 8'h00);
		emc_emulator_inst.space(sel, oe);
		emc_emulator_inst.strobe(1'b0, 1'b1);
		repeat (2) @(negedge i_sys_clk);
		check(o_access.internal_space, !lvl);
		if (!lvl) check(o_access, 3'h6);
		check(o_pindrv, {lvl, std & lvl, std & lvl});
		if (std) begin
			i_port_float_control = 1'b0;
			repeat (2) @(negedge i_sys_clk);
			check(o_pindrv, {lvl, lvl, 1'b0});
			i_port_float_control = 1'b1;
		end
		emc_emulator_inst.strobe(1'b1, 1'b0);
		repeat (2) @(negedge i_sys_clk);
		if (!lvl) check(o_access, 3'h5);
		emc_emulator_inst.strobe(1'b1, 1'b1);
		emc_emulator_inst.request(1'b0);
		n = 0;
		while (o_ir_load !== 1'b1 && n < 10) begin
			@(negedge i_sys_clk);
			n++;
		end
		check(o_instruction_register, OPC_NOP);
		check(o_core_freeze, 1'b0);
		n = 0;
		while (o_emulation_active !== 1'b0 && n < 40) begin
			@(negedge i_sys_clk);
			n++;
		end
		check(n >= 8 && n < 40, 1'b1);
		@(negedge i_sys_clk);
		check(o_access, 3'h0);
		check(o_standard_type, std);
	endtask : t_emu
	// Clock enable low must stop the machine cycle pulse entirely
	task automatic t_hold();
		int p = 0;
		@(negedge i_sys_clk);
		i_ce = 1'b0;
		repeat (24) begin
			@(negedge i_sys_clk);
			p += o_s1_phase_clock;
		end
		i_ce = 1'b1;
		check(p, 8'h00);
	endtask : t_hold
	initial begin
		t_reset(1'b1);
		t_normal();
		t_period();
		t_hold();
		t_period();
		t_emu(1'b0, 1'b1, 1'b0);
		t_emu(1'b1, 1'b1, 1'b0);
		t_emu(1'b1, 1'b0, 1'b0);
		t_reset(1'b0);
		t_emu(1'b1, 1'b1, 1'b1);
		t_period();
		close_out();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		#100us;
		error_cnt++;
		close_out();
	end
endmodule : emc_bench
